// ### design/sup_top.sv
// Signal limit supervision: registers, six comparators, reactions, interrupt
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "sup_consts.svh"

// Function
// - Status bit n-1 is one while signal of function n is outside limits.
// - Status word shows only in/out of limits; resets to zero.
// - Status bits come from comparison alone, not from configured reaction.
// - Selected signal compared with low and high limits; reaction chosen separately.
// - Mode 0 disables the function; condition never asserted.
// - Mode 1 asserts when signal below low limit minus half hysteresis.
// - Mode 1 clears when signal above low limit plus half hysteresis.
// - Mode 2 asserts when signal above high limit plus half hysteresis.
// - Mode 2 clears when signal below high limit minus half hysteresis.
// - Mode 3 asserts when magnitude below low limit magnitude minus half hysteresis.
// - Mode 3 clears when magnitude above low limit magnitude plus half hysteresis.
// - Mode 4 asserts when magnitude above high limit magnitude plus half hysteresis.
// - Mode 4 clears when magnitude below high limit magnitude minus half hysteresis.
// - Action 0 none, 1 warning, 2 fault, 3 fault only while running.
module sup_top (
  input  wire logic                     clk_in,       // Control clock, 50 MHz
  input  wire logic                     rst_n_in,     // Async reset, active low
  input  wire logic [`SUP_ADDR_W-1:0]   addr_in,      // Register address
  input  wire logic [`SUP_DATA_W-1:0]   wdata_in,     // Write data
  input  wire logic                     wr_in,        // Write strobe
  input  wire logic                     rd_in,        // Read strobe
  output logic      [`SUP_DATA_W-1:0]   rdata_out,    // Read data, cycle after strobe
  input  wire logic signed [15:0]       speed_in,     // Motor speed sample
  input  wire logic signed [15:0]       freq_in,      // Output frequency sample
  input  wire logic signed [15:0]       current_in,   // Motor current sample
  input  wire logic                     running_in,   // Motor running
  output logic      [`SUP_DATA_W-1:0]   status_out,   // Supervision status word
  output logic                          warning_out,  // Supervision warning level
  output logic                          fault_out,    // Supervision fault level
  output logic                          irq_out       // Interrupt, level
);
  import sup_pkg::*;

  localparam int NCH = `SUP_NUM_CH;

  logic [`SUP_DATA_W-1:0] ctrl_r  [NCH];
  logic [`SUP_DATA_W-1:0] low_r   [NCH];
  logic [`SUP_DATA_W-1:0] high_r  [NCH];
  logic [`SUP_DATA_W-1:0] hyst_r  [NCH];
  logic [NCH-1:0]         outside_c;
  logic [NCH-1:0]         outside_prev_r;
  logic [NCH-1:0]         irq_stat_r;
  logic [NCH-1:0]         irq_stat_nxt;
  logic [NCH-1:0]         irq_mask_r;
  logic [NCH-1:0]         warn_c;
  logic [NCH-1:0]         fault_c;
  logic [NCH-1:0]         warn_r;
  logic [NCH-1:0]         fault_r;
  logic [`SUP_DATA_W-1:0] status_r;
  logic [`SUP_DATA_W-1:0] rdata_r;
  logic [`SUP_DATA_W-1:0] rdata_nxt;
  logic [`SUP_ADDR_W-1:0] ch_off;
  logic                   ch_hit;
  logic [2:0]             ch_idx;
  logic [1:0]             ch_reg;

  // Per-channel window decode
  assign ch_hit = (addr_in >= `SUP_CH_BASE) && (addr_in < `SUP_CH_BASE + `SUP_CH_SPAN);
  assign ch_off = addr_in - `SUP_CH_BASE;
  assign ch_idx = ch_off[4:2];
  assign ch_reg = ch_off[1:0];

  // Channel configuration registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= `SUP_CTRL_RST;
        low_r[i]  <= `SUP_LIMIT_RST;
        high_r[i] <= `SUP_LIMIT_RST;
        hyst_r[i] <= `SUP_HYST_RST;
      end
    end else if (wr_in && ch_hit) begin
      case (ch_reg)
        `SUP_CH_CTRL: ctrl_r[ch_idx] <= wdata_in;
        `SUP_CH_LOW:  low_r[ch_idx]  <= wdata_in;
        `SUP_CH_HIGH: high_r[ch_idx] <= wdata_in;
        `SUP_CH_HYST: hyst_r[ch_idx] <= wdata_in;
        default:      ctrl_r[ch_idx] <= ctrl_r[ch_idx];
      endcase
    end
  end

  // Signal selection and one comparator per function
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    sup_cmp_if          link_if ();
    logic signed [15:0] sel_sample;

    always_comb begin
      case (ctrl_r[g][`SUP_SEL_MSB:`SUP_SEL_LSB])
        SEL_SPEED:   sel_sample = speed_in;
        SEL_FREQ:    sel_sample = freq_in;
        SEL_CURRENT: sel_sample = current_in;
        default:     sel_sample = 16'sh0000;
      endcase
    end

    assign link_if.sample     = sel_sample;
    assign link_if.low_limit  = signed'(low_r[g]);
    assign link_if.high_limit = signed'(high_r[g]);
    assign link_if.hyst       = hyst_r[g];
    assign link_if.mode       = ctrl_r[g][`SUP_MODE_MSB:`SUP_MODE_LSB];
    assign outside_c[g]       = link_if.outside;

    sup_cmp u_cmp (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .link     (link_if.cmp)
    );

    // Reaction decode; never feeds back into the status word
    always_comb begin
      warn_c[g]  = 1'b0;
      fault_c[g] = 1'b0;
      case (action_type'(ctrl_r[g][`SUP_ACT_MSB:`SUP_ACT_LSB]))
        ACT_WARNING:   warn_c[g]  = outside_c[g];
        ACT_FAULT:     fault_c[g] = outside_c[g];
        ACT_FAULT_RUN: fault_c[g] = outside_c[g] & running_in;
        default:       warn_c[g]  = 1'b0;
      endcase
    end
  end

  // Status word: comparison results only, reserved bits zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= `SUP_STATUS_RST;
    end else begin
      status_r <= {{(`SUP_DATA_W-NCH){1'b0}}, outside_c};
    end
  end

  // Reaction outputs, registered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warn_r  <= '0;
      fault_r <= '0;
    end else begin
      warn_r  <= warn_c;
      fault_r <= fault_c;
    end
  end

  // Sticky entry events; a new event beats a same-cycle clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_in && addr_in == `SUP_IRQ_STAT_OFF) begin
      irq_stat_nxt = irq_stat_nxt & ~wdata_in[NCH-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | (outside_c & ~outside_prev_r);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      outside_prev_r <= '0;
      irq_stat_r     <= '0;
    end else begin
      outside_prev_r <= outside_c;
      irq_stat_r     <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= `SUP_MASK_RST;
    end else if (wr_in && addr_in == `SUP_IRQ_MASK_OFF) begin
      irq_mask_r <= wdata_in[NCH-1:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (ch_hit) begin
      case (ch_reg)
        `SUP_CH_CTRL: rdata_nxt = ctrl_r[ch_idx];
        `SUP_CH_LOW:  rdata_nxt = low_r[ch_idx];
        `SUP_CH_HIGH: rdata_nxt = high_r[ch_idx];
        `SUP_CH_HYST: rdata_nxt = hyst_r[ch_idx];
        default:      rdata_nxt = '0;
      endcase
    end else begin
      case (addr_in)
        `SUP_STATUS_OFF:   rdata_nxt = status_r;
        `SUP_IRQ_STAT_OFF: rdata_nxt = {{(`SUP_DATA_W-NCH){1'b0}}, irq_stat_r};
        `SUP_IRQ_MASK_OFF: rdata_nxt = {{(`SUP_DATA_W-NCH){1'b0}}, irq_mask_r};
        `SUP_REACT_OFF:    rdata_nxt = {2'b00, fault_r, 2'b00, warn_r};
        default:           rdata_nxt = '0;
      endcase
    end
  end

  // Data held only for the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= '0;
    end else if (rd_in) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out   = rdata_r;
  assign status_out  = status_r;
  assign warning_out = |warn_r;
  assign fault_out   = |fault_r;
  assign irq_out     = |(irq_stat_r & irq_mask_r);
endmodule : sup_top

// ### design/sup_consts.svh
// Offsets, field positions, reset values and sizes for limit supervision
`ifndef SUP_CONSTS_SVH
`define SUP_CONSTS_SVH
`define SUP_NUM_CH        6
`define SUP_DATA_W        16
`define SUP_ADDR_W        8
`define SUP_STATUS_OFF    8'h00
`define SUP_IRQ_STAT_OFF  8'h01
`define SUP_IRQ_MASK_OFF  8'h02
`define SUP_REACT_OFF     8'h03
`define SUP_CH_BASE       8'h10
`define SUP_CH_SPAN       8'h18
`define SUP_CH_CTRL       2'h0
`define SUP_CH_LOW        2'h1
`define SUP_CH_HIGH       2'h2
`define SUP_CH_HYST       2'h3
`define SUP_MODE_LSB      0
`define SUP_MODE_MSB      3
`define SUP_ACT_LSB       4
`define SUP_ACT_MSB       5
`define SUP_SEL_LSB       8
`define SUP_SEL_MSB       10
`define SUP_STATUS_RST    16'h0000
`define SUP_CTRL_RST      16'h0300
`define SUP_LIMIT_RST     16'h0000
`define SUP_HYST_RST      16'h0000
`define SUP_MASK_RST      6'h00
`define SUP_WARN_LSB      0
`define SUP_FAULT_LSB     8
`endif

// ### design/sup_pkg.sv
// Types shared by limit supervision modules
package sup_pkg;
  typedef enum logic [3:0] {
    MODE_DISABLED = 4'h0,
    MODE_LOW      = 4'h1,
    MODE_HIGH     = 4'h2,
    MODE_ABS_LOW  = 4'h3,
    MODE_ABS_HIGH = 4'h4
  } mode_type;
  typedef enum logic [1:0] {
    ACT_NONE      = 2'h0,
    ACT_WARNING   = 2'h1,
    ACT_FAULT     = 2'h2,
    ACT_FAULT_RUN = 2'h3
  } action_type;
  typedef enum logic [2:0] {
    SEL_ZERO    = 3'h0,
    SEL_SPEED   = 3'h1,
    SEL_FREQ    = 3'h3,
    SEL_CURRENT = 3'h4
  } select_type;
endpackage : sup_pkg

// ### design/sup_cmp_if.sv
// Link between the register block and one limit comparator
`timescale 1ns/100ps
interface sup_cmp_if;
  import sup_pkg::*;
  logic signed [15:0] sample;
  logic signed [15:0] low_limit;
  logic signed [15:0] high_limit;
  logic        [15:0] hyst;
  logic        [3:0]  mode;
  logic               outside;
  modport ctrl (output sample, output low_limit, output high_limit, output hyst,
                output mode, input outside);
  modport cmp  (input sample, input low_limit, input high_limit, input hyst,
                input mode, output outside);
endinterface : sup_cmp_if

// ### design/sup_cmp.sv
// One limit comparator with hysteresis and held condition state
`timescale 1ns/100ps
module sup_cmp (
  input  wire logic clk_in,      // Control clock
  input  wire logic rst_n_in,    // Async reset, active low
  sup_cmp_if.cmp    link         // Sample, limits, mode, result
);
  import sup_pkg::*;

  logic signed [17:0] half;
  logic signed [17:0] s18;
  logic signed [17:0] lo18;
  logic signed [17:0] hi18;
  logic signed [17:0] s_abs;
  logic signed [17:0] lo_abs;
  logic signed [17:0] hi_abs;
  logic               set_c;
  logic               clr_c;
  logic               valid_c;
  logic               outside_r;

  function automatic logic signed [17:0] mag(input logic signed [17:0] x);
    mag = (x < 0) ? -x : x;
  endfunction : mag

  // 18 bits so limit plus half hysteresis never wraps
  assign half   = signed'({3'b000, link.hyst[15:1]});
  assign s18    = 18'(link.sample);
  assign lo18   = 18'(link.low_limit);
  assign hi18   = 18'(link.high_limit);
  assign s_abs  = mag(s18);
  assign lo_abs = mag(lo18);
  assign hi_abs = mag(hi18);

  always_comb begin
    set_c   = 1'b0;
    clr_c   = 1'b0;
    valid_c = 1'b1;
    case (link.mode)
      MODE_LOW: begin
        set_c = s18 < lo18 - half;
        clr_c = s18 > lo18 + half;
      end
      MODE_HIGH: begin
        set_c = s18 > hi18 + half;
        clr_c = s18 < hi18 - half;
      end
      MODE_ABS_LOW: begin
        set_c = s_abs < lo_abs - half;
        clr_c = s_abs > lo_abs + half;
      end
      MODE_ABS_HIGH: begin
        set_c = s_abs > hi_abs + half;
        clr_c = s_abs < hi_abs - half;
      end
      default: valid_c = 1'b0;
    endcase
  end

  // Evaluated every cycle; inside the band the old state holds
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      outside_r <= 1'b0;
    end else if (!valid_c) begin
      outside_r <= 1'b0;
    end else if (set_c) begin
      outside_r <= 1'b1;
    end else if (clr_c) begin
      outside_r <= 1'b0;
    end
  end

  assign link.outside = outside_r;
endmodule : sup_cmp

// ### bench/sup_top_assertions.sv
// Port-level checks for limit supervision
`timescale 1ns/100ps
module sup_checker (
  input wire logic               clk_in,      // Clock
  input wire logic               rst_n_in,    // Reset, active low
  input wire logic [7:0]         addr_in,     // Address
  input wire logic               wr_in,       // Write strobe
  input wire logic               rd_in,       // Read strobe
  input wire logic [15:0]        rdata_out,   // Read data
  input wire logic signed [15:0] speed_in,    // Sample
  input wire logic signed [15:0] freq_in,     // Sample
  input wire logic signed [15:0] current_in,  // Sample
  input wire logic [15:0]        status_out,  // Status word
  input wire logic               warning_out, // Warning
  input wire logic               fault_out,   // Fault
  input wire logic               irq_out      // Interrupt
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  reserved_zero_a: assert property (status_out[15:6] == 10'h000)
    else $error("reserved status bits set");
  status_read_a: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == $past(status_out))
    else $error("status read mismatch");
  idle_read_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (rd_in && addr_in == 8'h04 |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  warn_cause_a: assert property (warning_out |-> status_out[5:0] != 6'h00)
    else $error("warning with no status bit");
  fault_cause_a: assert property (fault_out |-> |status_out[5:0])
    else $error("fault with no status bit");
  // Status lags the samples by two edges; one update with held inputs is idempotent
  status_hold_a: assert property ($stable(speed_in) && $stable(freq_in) && $stable(current_in)
    && !$past(wr_in) |=> ##1 $stable(status_out))
    else $error("status moved with inputs held");
  irq_cause_a: assert property ($rose(irq_out) |-> $past(wr_in) || $changed(status_out))
    else $error("interrupt rose without cause");
  warn_c: cover property ($rose(warning_out));
  fault_c: cover property ($rose(fault_out));
  irq_c: cover property ($rose(irq_out));
endmodule : sup_checker
bind sup_top sup_checker chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .speed_in(speed_in), .freq_in(freq_in),
  .current_in(current_in), .status_out(status_out), .warning_out(warning_out),
  .fault_out(fault_out), .irq_out(irq_out));

// ### bench/signal_limit_supervision_bench.sv
// Register-level tests of limit supervision
`timescale 1ns/100ps
`include "sup_consts.svh"
module signal_limit_supervision_bench;
  logic               clk_in, rst_n_in, wr_in, rd_in, running_in;
  logic [7:0]         addr_in;
  logic [15:0]        wdata_in, rdata_out, status_out;
  logic signed [15:0] speed_in, freq_in, current_in;
  logic               warning_out, fault_out, irq_out;
  int                 num_errors, samples_checked;
  sup_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .speed_in(speed_in),
    .freq_in(freq_in), .current_in(current_in), .running_in(running_in),
    .status_out(status_out), .warning_out(warning_out), .fault_out(fault_out),
    .irq_out(irq_out));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] exp, string name);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(name, exp, rdata_out);
  endtask : rd
  task automatic cfg(int ch, logic [15:0] ctrl, logic [15:0] lo, logic [15:0] hi,
                     logic [15:0] hy);
    logic [7:0] b;
    b = `SUP_CH_BASE + 8'(4 * ch);
    wr(b + 8'h01, lo);
    wr(b + 8'h02, hi);
    wr(b + 8'h03, hy);
    wr(b, ctrl);
  endtask : cfg
  // Three edges cover comparator and status register, with one spare
  task automatic st(int src, logic signed [15:0] v, logic [15:0] exp);
    @(posedge clk_in);
    if (src == 1) speed_in <= v;
    else if (src == 2) freq_in <= v;
    else current_in <= v;
    repeat (3) @(posedge clk_in);
    #1 chk("status", exp, status_out);
  endtask : st
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // Whole run is well under a thousand cycles
  initial begin
    #(20 * 20000);
    num_errors++;
    conclude();
  end
  initial begin
    rst_n_in = 1'b0;
    {wr_in, rd_in, running_in, addr_in, wdata_in} = '0;
    {speed_in, freq_in, current_in} = '0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(`SUP_STATUS_OFF, `SUP_STATUS_RST, "status");
    rd(`SUP_CH_BASE, `SUP_CTRL_RST, "ctrl");
    rd(`SUP_IRQ_MASK_OFF, 16'h0000, "mask");
    rd(8'h04, 16'h0000, "unmapped");
    wr(`SUP_STATUS_OFF, 16'hffff);
    rd(`SUP_STATUS_OFF, 16'h0000, "status ro");
    wr(`SUP_IRQ_MASK_OFF, 16'h0001);
    // Park the sample past the clear point, or enabling the mode trips at once
    speed_in <= 16'sd106;
    cfg(0, 16'h0111, 16'd100, 16'd0, 16'd10);
    st(1, 16'sd96, 16'h0000);
    st(1, 16'sd94, 16'h0001);
    chk("warning", 16'h0001, 16'(warning_out));
    chk("irq", 16'h0001, 16'(irq_out));
    rd(`SUP_IRQ_STAT_OFF, 16'h0001, "irq status");
    rd(`SUP_REACT_OFF, 16'h0001, "reaction");
    st(1, 16'sd105, 16'h0001);
    st(1, 16'sd106, 16'h0000);
    chk("warning", 16'h0000, 16'(warning_out));
    wr(`SUP_IRQ_STAT_OFF, 16'h0001);
    #1 chk("irq", 16'h0000, 16'(irq_out));
    st(1, 16'sd90, 16'h0001);
    wr(8'h10, 16'h0110);
    st(1, 16'sd80, 16'h0000);
    wr(`SUP_IRQ_STAT_OFF, 16'h003f);
    cfg(1, 16'h0322, 16'd0, 16'd200, 16'd10);
    st(2, 16'sd205, 16'h0000);
    st(2, 16'sd206, 16'h0002);
    chk("fault", 16'h0001, 16'(fault_out));
    chk("irq masked", 16'h0000, 16'(irq_out));
    rd(`SUP_IRQ_STAT_OFF, 16'h0002, "irq status");
    st(2, 16'sd195, 16'h0002);
    st(2, 16'sd194, 16'h0000);
    wr(8'h14, 16'h0000);
    current_in <= 16'sd111;
    cfg(2, 16'h0433, 16'hff9c, 16'd0, 16'd20);
    st(3, -16'sd91, 16'h0000);
    st(3, -16'sd89, 16'h0004);
    chk("fault idle", 16'h0000, 16'(fault_out));
    running_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk("fault run", 16'h0001, 16'(fault_out));
    st(3, -16'sd110, 16'h0004);
    st(3, 16'sd111, 16'h0000);
    running_in <= 1'b0;
    wr(8'h18, 16'h0000);
    cfg(3, 16'h0304, 16'hfed4, 16'hfed4, 16'd8);
    st(2, 16'sd304, 16'h0000);
    st(2, -16'sd305, 16'h0008);
    chk("no reaction", 16'h0000, 16'({warning_out, fault_out}));
    st(2, 16'sd296, 16'h0008);
    st(2, 16'sd295, 16'h0000);
    conclude();
  end
endmodule : signal_limit_supervision_bench
